//--- common/sbfw_defs.svh
// offsets, field positions, reset values and counts for the sample buffer control block
`ifndef SBFW_DEFS_SVH
`define SBFW_DEFS_SVH

`define SBFW_CFG2_ADDR 8'h27
`define SBFW_CFG2_RESET 8'h00
`define SBFW_FLUSH_BIT 7
`define SBFW_HOLD_BIT 6
`define SBFW_WMRK_MSB 5
`define SBFW_WMRK_LSB 0
`define SBFW_DEPTH 32
`define SBFW_CNT_W 6
`define SBFW_GATE_CNT_W 5
`define SBFW_SLEEP_CNT_W 8

`endif

//--- common/sbfw_pkg.sv
// types shared by the sample buffer control block
package sbfw_pkg;

  typedef enum logic [1:0] {
    SBFW_MODE_OFF = 2'h0,
    SBFW_MODE_STREAM = 2'h1,
    SBFW_MODE_STOP = 2'h2,
    SBFW_MODE_TRIG = 2'h3
  } sbfw_mode_t;

  typedef enum logic [1:0] {
    SBFW_PS_WAKE = 2'h1,
    SBFW_PS_SLEEP = 2'h2
  } sbfw_pstate_t;

endpackage : sbfw_pkg

//--- rtl/sbfw_sleep_timer.sv
// auto-sleep timer: counts output-data-rate ticks while awake and flags expiry
`timescale 1ns/1ps
`default_nettype none
module sbfw_sleep_timer #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // control
  input wire logic tick_in,
  input wire logic restart_in,
  input wire logic run_in,
  input wire logic [CW-1:0] limit_in,
  // status
  output logic expired_out
);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_expired;

  always_comb begin
    next_count = count;
    next_expired = expired_out;
    if (restart_in || !run_in || limit_in == '0) begin
      next_count = '0;
      next_expired = 1'b0;
    end else if (tick_in && !expired_out) begin
      next_count = count + 1'b1;
      next_expired = (next_count == limit_in);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      expired_out <= 1'b0;
    end else begin
      count <= next_count;
      expired_out <= next_expired;
    end
  end

endmodule : sbfw_sleep_timer
`default_nettype wire

//--- rtl/sbfw_ctrl.sv
// sample buffer flush, watermark and wake-hold control
// Operation
// - writing one to the flush bit discards samples and clears buffer event flags
// - flush also clears the gate error flag and the five-bit gate count
// - flush bit self-clears at once and always reads back as zero
// - wake-hold bit zero: watermark and overflow flags ignored for wake-to-sleep
// - wake-hold bit one: sleep at timer expiry if either flag still set
// - host clearing the flags by flush or readout restarts timer, stays awake
// - wake-hold bit acts only in stream or stop buffering mode
// - watermark flag set while sample count is at least the watermark level
// - watermark level zero never raises the watermark flag
// - triggered mode: watermark level caps samples kept before the trigger
// - mode off disables buffer, flushes, clears overflow, watermark and count
`timescale 1ns/1ps
`default_nettype none
`include "sbfw_defs.svh"
module sbfw_ctrl #(
  parameter int DEPTH = `SBFW_DEPTH,
  parameter int CNT_W = `SBFW_CNT_W,
  parameter int SLEEP_W = `SBFW_SLEEP_CNT_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port from the serial front end
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // buffer datapath events
  input wire sbfw_pkg::sbfw_mode_t buf_mode_in,
  input wire logic sample_push_in,
  input wire logic sample_pop_in,
  input wire logic trigger_in,
  input wire logic gate_err_set_in,
  input wire logic gate_cnt_inc_in,
  // auto wake/sleep
  input wire logic odr_tick_in,
  input wire logic [SLEEP_W-1:0] sleep_timeout_count_in,
  input wire logic wake_event_in,
  input wire logic activity_in,
  // status and commands to the datapath
  output logic flush_out,
  output logic push_accept_out,
  output logic drop_oldest_out,
  output logic [CNT_W-1:0] sample_count_out,
  output logic watermark_flag_out,
  output logic overflow_flag_out,
  output logic gate_err_out,
  output logic [`SBFW_GATE_CNT_W-1:0] gate_cnt_out,
  output logic triggered_out,
  output logic sleep_mode_out
);
  import sbfw_pkg::*;

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic wake_hold_source;
  logic [`SBFW_WMRK_MSB:0] watermark_level;
  logic next_wake_hold_source;
  logic [`SBFW_WMRK_MSB:0] next_watermark_level;
  logic [7:0] next_rdata;
  logic cfg_wr;
  logic flush_cmd;

  assign cfg_wr = reg_wr_in && (reg_addr_in == `SBFW_CFG2_ADDR);
  // a zero in the flush bit is a plain store with no side effect
  assign flush_cmd = cfg_wr && reg_wdata_in[`SBFW_FLUSH_BIT];

  always_comb begin
    next_wake_hold_source = wake_hold_source;
    next_watermark_level = watermark_level;
    next_rdata = reg_rdata_out;
    if (cfg_wr) begin
      next_wake_hold_source = reg_wdata_in[`SBFW_HOLD_BIT];
      next_watermark_level = reg_wdata_in[`SBFW_WMRK_MSB:`SBFW_WMRK_LSB];
    end
    if (reg_rd_in) begin
      next_rdata = 8'h00;
      if (reg_addr_in == `SBFW_CFG2_ADDR) begin
        // the flush bit is never stored, so it reads back as zero
        next_rdata = {1'b0, wake_hold_source, watermark_level};
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_hold_source <= 1'(`SBFW_CFG2_RESET >> `SBFW_HOLD_BIT);
      watermark_level <= '0;
      reg_rdata_out <= 8'h00;
    end else begin
      wake_hold_source <= next_wake_hold_source;
      watermark_level <= next_watermark_level;
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // sample count, flags and gate fields
  // ----------------------------------------------------------------
  logic buf_off;
  logic clear_all;
  logic full;
  logic pop_ok;
  logic cap_hit;
  logic stop_push;
  logic [CNT_W-1:0] cap;
  logic [CNT_W-1:0] next_count;
  logic next_wmrk;
  logic next_ovf;
  logic next_gate_err;
  logic [`SBFW_GATE_CNT_W-1:0] next_gate_cnt;
  logic next_trig;
  logic next_accept;
  logic next_drop;
  logic emptied;

  assign buf_off = (buf_mode_in == SBFW_MODE_OFF);
  assign clear_all = flush_cmd || buf_off;
  assign full = (sample_count_out == CNT_W'(DEPTH));
  // before the trigger the stored history is capped at the watermark level
  assign cap = (buf_mode_in == SBFW_MODE_TRIG && !triggered_out && watermark_level != '0) ?
               CNT_W'(watermark_level) : CNT_W'(DEPTH);
  assign cap_hit = (sample_count_out >= cap);
  // a full buffer in stop mode, or in trigger mode after the trigger, refuses further samples
  assign stop_push = full && (buf_mode_in == SBFW_MODE_STOP ||
                              (buf_mode_in == SBFW_MODE_TRIG && triggered_out));
  assign pop_ok = sample_pop_in && (sample_count_out != '0);
  assign emptied = pop_ok && !sample_push_in && (sample_count_out == CNT_W'(1));

  always_comb begin
    next_count = sample_count_out;
    next_ovf = overflow_flag_out;
    next_gate_err = gate_err_out;
    next_gate_cnt = gate_cnt_out;
    next_trig = triggered_out;
    next_accept = 1'b0;
    next_drop = 1'b0;
    if (pop_ok) begin
      next_count = next_count - 1'b1;
      // reading a sample releases the overflow condition
      next_ovf = 1'b0;
    end
    if (sample_push_in && !stop_push && !buf_off) begin
      next_accept = 1'b1;
      if (cap_hit && !pop_ok) begin
        next_drop = 1'b1;
      end else begin
        next_count = next_count + 1'b1;
      end
      if (full && !pop_ok) begin
        next_ovf = 1'b1;
      end
    end else if (sample_push_in && stop_push) begin
      next_ovf = 1'b1;
    end
    if (buf_mode_in == SBFW_MODE_TRIG && trigger_in) begin
      next_trig = 1'b1;
    end
    if (gate_cnt_inc_in) begin
      next_gate_cnt = gate_cnt_out + 1'b1;
    end
    if (clear_all || emptied) begin
      next_gate_err = 1'b0;
      next_gate_cnt = '0;
      next_trig = 1'b0;
    end
    if (clear_all) begin
      next_count = '0;
      next_ovf = 1'b0;
      next_accept = 1'b0;
      next_drop = 1'b0;
    end
    // a gate error raised in the clearing cycle is kept
    if (gate_err_set_in) begin
      next_gate_err = 1'b1;
    end
    if (buf_mode_in != SBFW_MODE_TRIG) begin
      next_trig = 1'b0;
    end
    // level zero disables the flag; the incoming level is used so the flag never lags a rewrite
    next_wmrk = (next_watermark_level != '0) &&
                (next_count >= CNT_W'(next_watermark_level));
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_count_out <= '0;
      watermark_flag_out <= 1'b0;
      overflow_flag_out <= 1'b0;
      gate_err_out <= 1'b0;
      gate_cnt_out <= '0;
      triggered_out <= 1'b0;
      push_accept_out <= 1'b0;
      drop_oldest_out <= 1'b0;
      flush_out <= 1'b0;
    end else begin
      sample_count_out <= next_count;
      watermark_flag_out <= next_wmrk;
      overflow_flag_out <= next_ovf;
      gate_err_out <= next_gate_err;
      gate_cnt_out <= next_gate_cnt;
      triggered_out <= next_trig;
      push_accept_out <= next_accept;
      drop_oldest_out <= next_drop;
      flush_out <= clear_all;
    end
  end

  // ----------------------------------------------------------------
  // auto wake/sleep
  // ----------------------------------------------------------------
  sbfw_pstate_t pstate;
  sbfw_pstate_t next_pstate;
  logic flags_set;
  logic flags_prev;
  logic host_cleared;
  logic hold_active;
  logic timer_restart;
  logic timer_expired;
  logic next_flags_prev;

  assign flags_set = watermark_flag_out || overflow_flag_out;
  // a falling edge of the flag pair from any cause, such as flush or readout, counts as host service
  assign host_cleared = flags_prev && !flags_set;
  assign hold_active = wake_hold_source &&
                       (buf_mode_in == SBFW_MODE_STREAM || buf_mode_in == SBFW_MODE_STOP);
  assign timer_restart = host_cleared || activity_in || (pstate != SBFW_PS_WAKE);
  assign next_flags_prev = flags_set;

  sbfw_sleep_timer #(
    .CW(SLEEP_W)
  ) u_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_in(odr_tick_in),
    .restart_in(timer_restart),
    .run_in(!(buf_mode_in == SBFW_MODE_TRIG && triggered_out)),
    .limit_in(sleep_timeout_count_in),
    .expired_out(timer_expired)
  );

  always_comb begin
    next_pstate = pstate;
    case (pstate)
      SBFW_PS_WAKE: begin
        if (timer_expired && !host_cleared) begin
          if (!hold_active) begin
            next_pstate = SBFW_PS_SLEEP;
          end else if (flags_set) begin
            // flags left unserviced until expiry let the part sleep
            next_pstate = SBFW_PS_SLEEP;
          end
        end
      end
      SBFW_PS_SLEEP: begin
        if (wake_event_in || (buf_mode_in == SBFW_MODE_TRIG && trigger_in)) begin
          next_pstate = SBFW_PS_WAKE;
        end
      end
      default: begin
        next_pstate = SBFW_PS_WAKE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pstate <= SBFW_PS_WAKE;
      flags_prev <= 1'b0;
      sleep_mode_out <= 1'b0;
    end else begin
      pstate <= next_pstate;
      flags_prev <= next_flags_prev;
      sleep_mode_out <= (next_pstate == SBFW_PS_SLEEP);
    end
  end

endmodule : sbfw_ctrl
`default_nettype wire

//--- tb/sbfw_ctrl_properties.sv
// concurrent checks on the ports of the sample buffer control block
`timescale 1ns/1ps
`default_nettype none
module sbfw_ctrl_props #(
  parameter int DEPTH = 32,
  parameter int CNT_W = 6,
  parameter int SLEEP_W = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // datapath and status
  input wire sbfw_pkg::sbfw_mode_t buf_mode_in,
  input wire logic sample_push_in,
  input wire logic sample_pop_in,
  input wire logic trigger_in,
  input wire logic flush_out,
  input wire logic push_accept_out,
  input wire logic drop_oldest_out,
  input wire logic [CNT_W-1:0] sample_count_out,
  input wire logic watermark_flag_out,
  input wire logic overflow_flag_out,
  input wire logic [4:0] gate_cnt_out,
  input wire logic triggered_out,
  input wire logic sleep_mode_out
);
  import sbfw_pkg::*;
  // shadow of the stored level and hold bit, since they only show on a read
  logic [5:0] lvl;
  logic [5:0] next_lvl;
  logic hold;
  logic next_hold;
  logic cfg_wr;
  assign cfg_wr = reg_wr_in && reg_addr_in == 8'h27;
  always_comb begin
    next_lvl = cfg_wr ? reg_wdata_in[5:0] : lvl;
    next_hold = cfg_wr ? reg_wdata_in[6] : hold;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvl <= 6'h00;
      hold <= 1'b0;
    end else begin
      lvl <= next_lvl;
      hold <= next_hold;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_flush_wr;
    cfg_wr && reg_wdata_in[7];
  endsequence
  sequence s_cleared;
    flush_out && sample_count_out == '0 && !watermark_flag_out && !overflow_flag_out;
  endsequence
  a_flush_clears: assert property (s_flush_wr |=> s_cleared ##0 gate_cnt_out == 5'h00)
    else $error("flush did not clear buffer state");
  a_flush_pulse: assert property (s_flush_wr ##1 (!cfg_wr && buf_mode_in != SBFW_MODE_OFF) |=> !flush_out)
    else $error("flush pulse did not end");
  a_read_bit7: assert property (reg_rd_in |=> !reg_rdata_out[7])
    else $error("flush bit read as one");
  a_wmrk_level: assert property (watermark_flag_out == (lvl != 6'h00 && sample_count_out >= lvl))
    else $error("watermark flag disagrees with count");
  a_wmrk_zero: assert property (lvl == 6'h00 |-> !watermark_flag_out)
    else $error("watermark flag with level zero");
  a_mode_off: assert property (buf_mode_in == SBFW_MODE_OFF |=> s_cleared)
    else $error("mode off did not clear buffer");
  a_off_refuse: assert property (buf_mode_in == SBFW_MODE_OFF && sample_push_in |=> !push_accept_out)
    else $error("push accepted in mode off");
  a_zero_write: assert property (cfg_wr && !reg_wdata_in[7] && buf_mode_in != SBFW_MODE_OFF && !sample_push_in
    && !sample_pop_in |=> !flush_out && $stable(sample_count_out))
    else $error("write of zero flush bit changed buffer");
  a_pretrig_cap: assert property (buf_mode_in == SBFW_MODE_TRIG && !triggered_out && !trigger_in && lvl != 6'h00
    && sample_count_out == lvl && sample_push_in && !sample_pop_in && !reg_wr_in |=> drop_oldest_out)
    else $error("pre-trigger samples exceed level");
  a_hold_awake: assert property (hold && (buf_mode_in == SBFW_MODE_STREAM || buf_mode_in == SBFW_MODE_STOP)
    && !watermark_flag_out && !overflow_flag_out && !sleep_mode_out |=> !sleep_mode_out)
    else $error("slept with hold active and no flags");
endmodule : sbfw_ctrl_props
bind sbfw_ctrl sbfw_ctrl_props #(.DEPTH(DEPTH), .CNT_W(CNT_W), .SLEEP_W(SLEEP_W)) i_props (
  .mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .buf_mode_in, .sample_push_in, .sample_pop_in, .trigger_in, .flush_out, .push_accept_out,
  .drop_oldest_out, .sample_count_out, .watermark_flag_out, .overflow_flag_out, .gate_cnt_out,
  .triggered_out, .sleep_mode_out
);
`default_nettype wire

//--- tb/sbfw_host.sv
// host model: register accesses and sample readout
`timescale 1ns/1ps
`default_nettype none
module sbfw_host (
  // clock
  input wire logic mclk_in,
  // register port
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  // readout
  output logic sample_pop_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    sample_pop_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1 reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge mclk_in);
    #1 reg_wr_out = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    #1 reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge mclk_in);
    #1 reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask : rd
  task automatic pop();
    @(posedge mclk_in);
    #1 sample_pop_out = 1'b1;
    @(posedge mclk_in);
    #1 sample_pop_out = 1'b0;
  endtask : pop
endmodule : sbfw_host
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the sample buffer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbfw_pkg::*;
  logic mclk_in, rst_n_in, wr, rd, pop, push, trig, gset, ginc, tick, wake, flush, wmrk, ovf, gerr, trgd, slp;
  logic acc, drop;
  logic [7:0] addr, wdata, rdata, tmo, v;
  logic [5:0] cnt;
  logic [4:0] gcnt;
  sbfw_mode_t mode;
  int miscompares, check_count;
  sbfw_ctrl i_dut (
    .mclk_in, .rst_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .buf_mode_in(mode), .sample_push_in(push), .sample_pop_in(pop),
    .trigger_in(trig), .gate_err_set_in(gset), .gate_cnt_inc_in(ginc), .odr_tick_in(tick),
    .sleep_timeout_count_in(tmo), .wake_event_in(wake), .activity_in(1'b0), .flush_out(flush),
    .push_accept_out(acc), .drop_oldest_out(drop), .sample_count_out(cnt), .watermark_flag_out(wmrk),
    .overflow_flag_out(ovf), .gate_err_out(gerr), .gate_cnt_out(gcnt), .triggered_out(trgd),
    .sleep_mode_out(slp)
  );
  sbfw_host i_host (.mclk_in, .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_rdata_in(rdata), .sample_pop_out(pop));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1 s = 1'b1;
    end
    @(posedge mclk_in);
    #1 s = 1'b0;
  endtask : pulse
  task automatic nap(input logic e);
    repeat (2) @(posedge mclk_in);
    #1 chk("sleep", {7'h00, e}, slp);
  endtask : nap
  task automatic end_sim();
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_in);
    miscompares++;
    end_sim();
  end
  initial begin
    {rst_n_in, push, trig, gset, ginc, tick, wake} = 7'h00;
    mode = SBFW_MODE_STREAM;
    tmo = 8'h02;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    i_host.rd(8'h27, v);
    chk("cfg reset", 8'h00, v);
    i_host.rd(8'h30, v);
    chk("unmapped", 8'h00, v);
    i_host.wr(8'h27, 8'h45);
    i_host.rd(8'h27, v);
    chk("cfg rw", 8'h45, v);
    pulse(push, 4);
    chk("wmrk below", 8'h00, wmrk);
    pulse(push, 1);
    chk("wmrk at", 8'h01, wmrk);
    chk("accept", 8'h01, acc);
    pulse(gset, 1);
    chk("gate err set", 8'h01, gerr);
    pulse(ginc, 3);
    chk("gate cnt", 8'h03, gcnt);
    i_host.wr(8'h27, 8'h05);
    chk("count kept", 8'h05, cnt);
    chk("no flush", 8'h00, flush);
    i_host.wr(8'h27, 8'h85);
    chk("flush", 8'h01, flush);
    chk("count", 8'h00, cnt);
    chk("gate err", 8'h00, gerr);
    chk("gate cnt", 8'h00, gcnt);
    i_host.rd(8'h27, v);
    chk("flush bit", 8'h05, v);
    i_host.wr(8'h27, 8'h80);
    pulse(push, 3);
    chk("wmrk zero", 8'h00, wmrk);
    $display("test flush and watermark done");
    mode = SBFW_MODE_STOP;
    pulse(push, 33);
    chk("ovf", 8'h01, ovf);
    pulse(tick, 1);
    i_host.pop();
    pulse(tick, 1);
    nap(1'b0);
    pulse(tick, 1);
    nap(1'b1);
    pulse(wake, 1);
    nap(1'b0);
    i_host.wr(8'h27, 8'hc0);
    pulse(push, 33);
    pulse(tick, 2);
    nap(1'b1);
    pulse(wake, 1);
    i_host.wr(8'h27, 8'hc0);
    pulse(tick, 2);
    nap(1'b0);
    $display("test sleep done");
    mode = SBFW_MODE_TRIG;
    i_host.wr(8'h27, 8'hc3);
    pulse(push, 5);
    chk("pre-trigger cap", 8'h03, cnt);
    chk("drop oldest", 8'h01, drop);
    pulse(trig, 1);
    chk("trigger", 8'h01, trgd);
    mode = SBFW_MODE_OFF;
    @(posedge mclk_in);
    #1 chk("off count", 8'h00, cnt);
    chk("off flush", 8'h01, flush);
    pulse(tick, 2);
    nap(1'b1);
    $display("test modes done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
